//--- rts_bp_model.sv
// Backplane receiver model: paces the bit enable and rebuilds octets
`timescale 1ns/100ps
module rts_bp_model (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pacing control
	input wire logic slow,
	input wire logic stall,
	// Serial stream from the core
	input wire logic pcm_out,
	input wire logic pcm_valid,
	input wire logic pcm_fs,
	output logic bp_bit_en,
	// Rebuilt octets
	output logic oct_valid,
	output logic [7:0] oct,
	output logic [4:0] oct_ts
);
	int div;
	int bits;
	logic [4:0] slot;
	logic [7:0] sh;
	// Enable never faster than every other cycle, though the serializer can take one every cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div = 0;
			bits = 0;
			slot = 5'h00;
			sh = 8'h00;
			bp_bit_en <= 1'b0;
			oct_valid <= 1'b0;
			oct <= 8'h00;
			oct_ts <= 5'h00;
		end else begin
			bp_bit_en <= !stall && div == 0;
			div = (div >= (slow ? 2 : 1)) ? 0 : div + 1;
			oct_valid <= 1'b0;
			if (pcm_valid) begin
				if (pcm_fs) begin
					bits = 0;
					slot = 5'h00;
				end
				sh = {sh[6:0], pcm_out};
				bits++;
				if (bits == 8) begin
					oct_valid <= 1'b1;
					oct <= sh;
					oct_ts <= slot;
					slot++;
					bits = 0;
				end
			end
		end
	end
endmodule

//--- rts_core.sv
// Receive timeslot conditioning, signaling substitution and debounce for one E1 channel
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module rts_core
	import rts_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Received line stream
	input wire logic line_bit,
	input wire logic line_bit_en,
	input wire logic line_frame_sync,
	input wire logic line_mf_sync,
	// Backplane side
	input wire logic bp_bit_en,
	output logic rx_pcm_serial_out,
	output logic rx_pcm_valid,
	output logic rx_pcm_frame_start,
	output logic [3:0] rx_signaling_bus_out,
	output logic rx_overhead_out
);
	// Per-slot control storage, then channel-wide pattern type, D/E source and status bit
	logic [3:0] ccr_q [NUM_TS];
	logic [7:0] ucr_q [NUM_TS];
	logic [2:0] scr_q [NUM_TS];
	logic [3:0] ssr_q [NUM_TS];
	logic [3:0] sar_q [NUM_TS];
	logic [3:0] prev_q [NUM_TS];
	logic test_pattern_type_q;
	logic [1:0] de_slot_source_select_q;
	logic ovf_q;

	// Line side counters
	logic [2:0] bit_q;
	logic [4:0] ts_q;
	logic [3:0] fr_q;
	logic [6:0] sh_q;

	// Backplane serializer
	rts_ser_t ser_q;
	rts_word_t word_q;
	logic [2:0] idx_q;
	logic pcm_q, pcm_v_q, pcm_fs_q, oh_q;
	logic [3:0] sigbus_q;
	logic [7:0] rdata_q;

	// Register decode
	wire [4:0] ridx = reg_addr[4:0];
	wire hit_ccr = (reg_addr[11:5] == CCR_BASE[11:5]);
	wire hit_ucr = (reg_addr[11:5] == UCR_BASE[11:5]);
	wire hit_scr = (reg_addr[11:5] == SCR_BASE[11:5]);
	wire hit_ssr = (reg_addr[11:5] == SSR_BASE[11:5]);
	wire hit_sar = (reg_addr[11:5] == SAR_BASE[11:5]);
	wire hit_pat = (reg_addr == PAT_CFG_ADDR);
	wire hit_de = (reg_addr == DE_CFG_ADDR);
	wire hit_stat = (reg_addr == STAT_ADDR);

	// Write enables, one per register group except SAR and STAT
	wire wr_ccr = reg_wr && hit_ccr;
	wire wr_ucr = reg_wr && hit_ucr;
	wire wr_scr = reg_wr && hit_scr;
	wire wr_ssr = reg_wr && hit_ssr;
	wire wr_pat = reg_wr && hit_pat;
	wire wr_de = reg_wr && hit_de;

	// Read value of each group; reserved bits read zero
	wire [7:0] rd_ccr = {4'h0, ccr_q[ridx]};
	wire [7:0] rd_ucr = ucr_q[ridx];
	wire [7:0] rd_scr = {1'b0, scr_q[ridx], 4'h0};
	wire [7:0] rd_ssr = {4'h0, ssr_q[ridx]};
	wire [7:0] rd_sar = {4'h0, sar_q[ridx]};
	wire [7:0] rd_pat = {test_pattern_type_q, 7'h00};
	wire [7:0] rd_de = {6'h00, de_slot_source_select_q};
	wire [7:0] rd_stat = {7'h00, ovf_q};
	wire [7:0] rd_val =
		hit_ccr ? rd_ccr :
		hit_ucr ? rd_ucr :
		hit_scr ? rd_scr :
		hit_ssr ? rd_ssr :
		hit_sar ? rd_sar :
		hit_pat ? rd_pat :
		hit_de ? rd_de :
		hit_stat ? rd_stat : 8'h00;

	// Line position; a frame sync marks bit 0 of slot 0
	wire [2:0] cur_bit = line_frame_sync ? 3'h0 : bit_q;
	wire [4:0] cur_ts = line_frame_sync ? 5'h00 : ts_q;
	wire [3:0] cur_fr = !line_frame_sync ? fr_q : line_mf_sync ? FRAME_MF : fr_q + 4'h1;
	wire oct_done = line_bit_en && (cur_bit == BIT_LAST);
	wire [7:0] rx_oct = {sh_q, line_bit};
	wire [3:0] sel = ccr_q[cur_ts];

	// Pattern sources
	wire [7:0] prbs_byte, qrts_byte;
	wire pat_step = oct_done && (sel == COND_PATTERN);
	wire [7:0] pat_byte = test_pattern_type_q ? qrts_byte : prbs_byte;
	// Only the selected generator advances, so each keeps its own sequence
	wire prbs_step = pat_step && !test_pattern_type_q;
	wire qrts_step = pat_step && test_pattern_type_q;

	rts_lfsr #(.WIDTH(PRBS_W), .TAP(PRBS_TAP)) u_prbs (
		.clk(clk),
		.resetn(resetn),
		.step(prbs_step),
		.pat_byte(prbs_byte)
	);

	rts_lfsr #(.WIDTH(QRTS_W), .TAP(QRTS_TAP)) u_qrts (
		.clk(clk),
		.resetn(resetn),
		.step(qrts_step),
		.pat_byte(qrts_byte)
	);

	// Octet conditioning on the slot's own select
	logic [7:0] cond_oct;
	always_comb begin
		cond_oct = rx_oct;
		unique case (sel)
			COND_PASS, COND_PASS2: cond_oct = rx_oct;
			COND_INV_ALL: cond_oct = rx_oct ^ MASK_ALL;
			COND_INV_EVEN: cond_oct = rx_oct ^ MASK_EVEN;
			COND_INV_ODD: cond_oct = rx_oct ^ MASK_ODD;
			COND_USER: cond_oct = ucr_q[cur_ts];
			COND_BUSY: cond_oct = CODE_BUSY;
			COND_VACANT: cond_oct = CODE_VACANT;
			COND_BUSY_TS: cond_oct = {BUSY_TS_PREFIX, cur_ts};
			COND_OOF: cond_oct = CODE_OOF;
			COND_ALAW: cond_oct = ALAW_DMW[fr_q[2:0]];
			COND_ULAW: cond_oct = ULAW_DMW[fr_q[2:0]];
			COND_INV_MSB: cond_oct = rx_oct ^ MASK_MSB;
			COND_INV_LOW: cond_oct = rx_oct ^ MASK_LOW;
			COND_PATTERN: cond_oct = pat_byte;
			COND_DE: cond_oct = (de_slot_source_select_q == DE_SRC_RX) ? rx_oct :
				(de_slot_source_select_q == DE_SRC_USER) ? ucr_q[cur_ts] : CODE_VACANT;
		endcase
	end

	// Signaling slot: frame n (1 to 15) carries slot n (high nibble) and slot n+16 (low nibble)
	wire sig_slot = oct_done && (cur_ts == TS_SIG) && (cur_fr != FRAME_MF);
	wire [4:0] hi_ts = {1'b0, cur_fr};
	wire [4:0] lo_ts = {1'b1, cur_fr};
	// Received ABCD of both carried slots, before any substitution
	wire [3:0] rx_hi_nib = rx_oct[7:4];
	wire [3:0] rx_lo_nib = rx_oct[3:0];
	wire sub_hi = scr_q[hi_ts][SUBST_BIT-4];
	wire sub_lo = scr_q[lo_ts][SUBST_BIT-4];

	// Substitution acts on the PCM copy only; the array sees rx_oct
	wire [7:0] out_oct = !sig_slot ? cond_oct :
		{sub_hi ? ssr_q[hi_ts] : cond_oct[7:4], sub_lo ? ssr_q[lo_ts] : cond_oct[3:0]};

	// Debounce: commit only when this superframe matches the previous one
	wire deb_hi = scr_q[hi_ts][DEB_BIT-4];
	wire deb_lo = scr_q[lo_ts][DEB_BIT-4];
	wire upd_hi = !deb_hi || (rx_hi_nib == prev_q[hi_ts]);
	wire upd_lo = !deb_lo || (rx_lo_nib == prev_q[lo_ts]);

	// Elastic buffer toward the backplane
	rts_word_t fifo_in, fifo_out;
	logic fifo_in_ready, fifo_out_valid;
	wire fifo_out_ready = (ser_q == SER_IDLE);
	assign fifo_in = '{ts: cur_ts, oct: out_oct};

	rts_fifo #(.WIDTH($bits(rts_word_t)), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(oct_done),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// The line cannot be stalled, so a full buffer drops the octet and flags it
	wire ovf_set = oct_done && !fifo_in_ready;
	wire ovf_clr = reg_wr && hit_stat && reg_wdata[OVF_BIT];

	// Per-slot conditioning select and user code
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_TS; i++) begin
				ccr_q[i] <= CCR_RESET;
				ucr_q[i] <= USER_RESET;
			end
		end else begin
			if (wr_ccr) ccr_q[ridx] <= reg_wdata[3:0];
			if (wr_ucr) ucr_q[ridx] <= reg_wdata;
		end
	end

	// Per-slot signaling control and substitution nibble
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_TS; i++) begin
				scr_q[i] <= SCR_RESET;
				ssr_q[i] <= SSR_RESET;
			end
		end else begin
			if (wr_scr) scr_q[ridx] <= reg_wdata[SUBST_BIT:DEB_BIT];
			if (wr_ssr) ssr_q[ridx] <= reg_wdata[3:0];
		end
	end

	// Channel-wide pattern type and D/E source
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			test_pattern_type_q <= 1'b0;
			de_slot_source_select_q <= DE_SRC_RX;
		end else begin
			if (wr_pat) test_pattern_type_q <= reg_wdata[PAT_TYPE_BIT];
			if (wr_de) de_slot_source_select_q <= reg_wdata[1:0];
		end
	end

	// Status and read data; a new overflow beats a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ovf_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
			rdata_q <= reg_rd ? rd_val : 8'h00;
		end
	end

	// Line counters and shift register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_q <= 3'h0;
			ts_q <= 5'h00;
			fr_q <= FRAME_MF;
			sh_q <= 7'h00;
		end else if (line_bit_en) begin
			bit_q <= cur_bit + 3'h1;
			ts_q <= (cur_bit == BIT_LAST) ? cur_ts + 5'h01 : cur_ts;
			fr_q <= cur_fr;
			sh_q <= rx_oct[6:0];
		end
	end

	// Received signaling array, always from the received bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_TS; i++) begin
				sar_q[i] <= 4'h0;
				prev_q[i] <= 4'h0;
			end
		end else if (sig_slot) begin
			prev_q[hi_ts] <= rx_hi_nib;
			prev_q[lo_ts] <= rx_lo_nib;
			if (upd_hi) sar_q[hi_ts] <= rx_hi_nib;
			if (upd_lo) sar_q[lo_ts] <= rx_lo_nib;
		end
	end

	// Serializer state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ser_q <= SER_IDLE;
			word_q <= '0;
			idx_q <= 3'h0;
		end else begin
			unique case (ser_q)
				SER_IDLE: if (fifo_out_valid) begin
					word_q <= fifo_out;
					idx_q <= 3'h0;
					ser_q <= SER_SHIFT;
				end
				SER_SHIFT: if (bp_bit_en) begin
					idx_q <= idx_q + 3'h1;
					if (idx_q == BIT_LAST) ser_q <= SER_IDLE;
				end
			endcase
		end
	end

	// Backplane outputs, one bit per enable, MSB first
	wire shifting = (ser_q == SER_SHIFT) && bp_bit_en;
	// Settings of the slot now on the backplane, read at send time
	wire [2:0] out_ctl = scr_q[word_q.ts];
	wire [3:0] out_sig = sar_q[word_q.ts];
	wire [1:0] oh_sel = 2'h3 - idx_q[1:0];
	wire pcm_bit = word_q.oct[3'h7 - idx_q];
	wire oh_on = out_ctl[OH_BIT-4] && (idx_q < OH_BITS);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pcm_q <= 1'b0;
			pcm_v_q <= 1'b0;
			pcm_fs_q <= 1'b0;
			sigbus_q <= 4'h0;
			oh_q <= 1'b0;
		end else begin
			pcm_v_q <= shifting;
			pcm_fs_q <= shifting && (idx_q == 3'h0) && (word_q.ts == 5'h00);
			if (shifting) begin
				pcm_q <= pcm_bit;
				if (idx_q == 3'h0) sigbus_q <= out_sig;
				// A goes out first, so the pin carries ABCD on bits 0 to 3
				oh_q <= oh_on ? out_sig[oh_sel] : 1'b0;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign rx_pcm_serial_out = pcm_q;
	assign rx_pcm_valid = pcm_v_q;
	assign rx_pcm_frame_start = pcm_fs_q;
	assign rx_signaling_bus_out = sigbus_q;
	assign rx_overhead_out = oh_q;
endmodule

//--- rts_core_sva.sv
// Assertion checker for the receive timeslot conditioning core
`timescale 1ns/100ps
module rts_core_sva
	import rts_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Line and backplane
	input wire logic bp_bit_en,
	input wire logic rx_pcm_serial_out,
	input wire logic rx_pcm_valid,
	input wire logic rx_pcm_frame_start,
	input wire logic [3:0] rx_signaling_bus_out,
	input wire logic rx_overhead_out
);
	logic ucw_q;
	logic scw_q;
	wire uc_hit = reg_addr[11:5] == UCR_BASE[11:5];
	wire sc_hit = reg_addr[11:5] == SCR_BASE[11:5];
	// Sticky flags: once software writes, reset values no longer apply
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ucw_q <= 1'b0;
			scw_q <= 1'b0;
		end else begin
			ucw_q <= ucw_q | (reg_wr & uc_hit);
			scw_q <= scw_q | (reg_wr & sc_hit);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_user_reset: assert property (reg_rd && uc_hit && !ucw_q |=> reg_rdata == 8'hFF)
		else $error("user code read differs from reset value");
	chk_ctrl_reset: assert property (reg_rd && sc_hit && !scw_q |=> reg_rdata == 8'h00)
		else $error("signaling control read differs from reset value");
	chk_oh_enable: assert property (rx_overhead_out |-> scw_q)
		else $error("overhead pin driven with no enable written");
	chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data present without a read");
	chk_valid_cause: assert property (rx_pcm_valid |-> $past(bp_bit_en))
		else $error("pcm bit without backplane enable");
	chk_fs_valid: assert property (rx_pcm_frame_start |-> rx_pcm_valid)
		else $error("frame start without pcm bit");
	chk_out_hold: assert property (!rx_pcm_valid |-> $stable(rx_pcm_serial_out) && $stable(rx_signaling_bus_out))
		else $error("pcm or signaling output moved between bits");
	chk_reset_quiet: assert property ($rose(resetn) |-> !rx_pcm_valid && !rx_overhead_out && rx_signaling_bus_out == 4'h0)
		else $error("outputs active right after reset");
	cover property (rx_pcm_frame_start);
	cover property (rx_overhead_out);
	cover property (reg_rd && reg_addr == STAT_ADDR);
endmodule
bind rts_core rts_core_sva #(.DEPTH(DEPTH)) u_sva (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .bp_bit_en, .rx_pcm_serial_out, .rx_pcm_valid, .rx_pcm_frame_start, .rx_signaling_bus_out,
	.rx_overhead_out);

//--- rts_core_tb.sv
// Self-checking testbench for the receive timeslot conditioning core
`timescale 1ns/100ps
module rts_core_tb;
	import rts_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [AW-1:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic line_bit = 1'b0;
	logic line_bit_en = 1'b0;
	logic line_frame_sync = 1'b0;
	logic line_mf_sync = 1'b0;
	logic slow = 1'b0;
	logic stall = 1'b0;
	logic ignore = 1'b0;
	logic rd_d = 1'b0;
	logic [7:0] reg_rdata;
	logic bp_bit_en, pcm_out, pcm_valid, pcm_fs, oh_out, oct_valid;
	logic [3:0] sig_bus;
	logic [7:0] oct;
	logic [4:0] oct_ts;
	logic [3:0] sel [32];
	logic [7:0] user [32];
	logic [3:0] ssr [32];
	logic [3:0] sig [32];
	logic [31:0] subst = '0;
	logic [14:0] pq [$];
	logic [7:0] rq [$];
	logic [14:0] e;
	int n_mismatch = 0;
	int total_checks = 0;
	int oh_cnt = 0;
	int fs_cnt = 0;
	logic sig_chk = 1'b0;
	logic pat_type = 1'b0;
	logic [1:0] de_src = 2'h0;
	logic [14:0] prbs_s = 15'h0001;
	logic [19:0] qrts_s = 20'h00001;
	always #5 clk = ~clk;
	rts_core #(.DEPTH(FIFO_DEPTH)) u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_bit(line_bit), .line_bit_en(line_bit_en),
		.line_frame_sync(line_frame_sync), .line_mf_sync(line_mf_sync), .bp_bit_en(bp_bit_en),
		.rx_pcm_serial_out(pcm_out), .rx_pcm_valid(pcm_valid), .rx_pcm_frame_start(pcm_fs),
		.rx_signaling_bus_out(sig_bus), .rx_overhead_out(oh_out));
	rts_bp_model u_bp (.clk(clk), .resetn(resetn), .slow(slow), .stall(stall), .pcm_out(pcm_out),
		.pcm_valid(pcm_valid), .pcm_fs(pcm_fs), .bp_bit_en(bp_bit_en), .oct_valid(oct_valid), .oct(oct),
		.oct_ts(oct_ts));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Sampled on the falling edge so registered outputs have settled
	always @(negedge clk) begin
		if (rd_d) cmp(reg_rdata, rq.pop_front());
		rd_d = reg_rd;
		if (oh_out) oh_cnt++;
		if (pcm_fs) fs_cnt++;
		if (oct_valid && !ignore && sig_chk && oct_ts == 5'd3) cmp({4'h0, sig_bus}, {4'h0, sig[3]});
		if (oct_valid && !ignore && sig_chk && oct_ts == 5'd6) cmp({4'h0, sig_bus}, 8'h0A);
		if (oct_valid && !ignore && pq.size() == 0) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, oct, 8'h00);
		end else if (oct_valid && !ignore) begin
			e = pq.pop_front();
			cmp({3'h0, oct_ts}, {3'h0, e[12:8]});
			case (e[14:13])
				2'd1: cmp({7'h0, oct inside {8'h34, 8'h21, 8'hB4, 8'hA1}}, 8'h01);
				2'd2: cmp({7'h0, oct inside {8'h1E, 8'h0B, 8'h9E, 8'h8B}}, 8'h01);
				default: cmp(oct, e[7:0]);
			endcase
		end
	end
	// Reference generators: x^15+x^14+1 or x^20+x^17+1, seed 1, eight bits per pattern octet
	function automatic logic [7:0] pat_next();
		logic [7:0] r;
		logic f;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			if (pat_type) begin
				f = qrts_s[19] ^ qrts_s[16];
				qrts_s = {qrts_s[18:0], f};
			end else begin
				f = prbs_s[14] ^ prbs_s[13];
				prbs_s = {prbs_s[13:0], f};
			end
			r[i] = f;
		end
		return r;
	endfunction
	function automatic logic [14:0] expect_oct(input logic [4:0] ts, input logic [7:0] o);
		logic [7:0] v;
		logic [1:0] m;
		m = 2'd0;
		v = o;
		case (sel[ts])
			4'h1: v = o ^ 8'hFF;
			4'h2: v = o ^ 8'hAA;
			4'h3: v = o ^ 8'h55;
			4'h4: v = user[ts];
			4'h5: v = 8'h7F;
			4'h6: v = 8'hFF;
			4'h7: v = {3'b111, ts};
			4'h8: v = 8'h1A;
			4'h9: m = 2'd1;
			4'hA: m = 2'd2;
			4'hB: v = o ^ 8'h80;
			4'hC: v = o ^ 8'h7F;
			4'hD: v = pat_next();
			4'hF: v = (de_src == 2'h1) ? user[ts] : (de_src == 2'h0) ? o : 8'hFF;
			default: v = o;
		endcase
		return {m, ts, v};
	endfunction
	// One line bit every fourth cycle keeps the backplane ahead of the line
	task automatic send_frame(input int fi);
		logic [7:0] o;
		logic [14:0] x;
		for (int ts = 0; ts < 32; ts++) begin
			o = 8'($urandom);
			if (ts == 16) o = (fi == 0) ? 8'h0B : {sig[fi], sig[fi + 16]};
			x = expect_oct(ts[4:0], o);
			if (ts == 16 && fi > 0 && subst[fi]) x[7:4] = ssr[fi];
			if (ts == 16 && fi > 0 && subst[fi + 16]) x[3:0] = ssr[fi + 16];
			for (int b = 7; b >= 0; b--) begin
				@(posedge clk);
				line_bit <= o[b];
				line_bit_en <= 1'b1;
				line_frame_sync <= ts == 0 && b == 7;
				line_mf_sync <= ts == 0 && b == 7 && fi == 0;
				@(posedge clk);
				line_bit_en <= 1'b0;
				line_frame_sync <= 1'b0;
				line_mf_sync <= 1'b0;
				repeat (2) @(posedge clk);
			end
			if (!ignore) pq.push_back(x);
		end
	endtask
	task automatic send_mf();
		for (int f = 0; f < 16; f++) send_frame(f);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(exp);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	initial begin
		repeat (70000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(56457));
		for (int t = 0; t < 32; t++) begin
			sel[t] = 4'h0;
			user[t] = 8'hFF;
			ssr[t] = 4'h0;
			sig[t] = 4'($urandom) | 4'h1;
		end
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rd(UCR_BASE + 12'd20, 8'hFF);
		rd(SCR_BASE + 12'd5, 8'h00);
		rd(12'hFFF, 8'h00);
		user[4] = 8'($urandom);
		wr(UCR_BASE + 12'd4, user[4]);
		rd(UCR_BASE + 12'd4, user[4]);
		for (int t = 1; t < 32; t++) begin
			if (t != 16) begin
				sel[t] = t[3:0];
				wr(CCR_BASE + 12'(t), {4'h0, sel[t]});
			end
		end
		subst[3] = 1'b1;
		subst[20] = 1'b1;
		ssr[3] = 4'h9;
		ssr[20] = 4'h6;
		wr(SSR_BASE + 12'd3, 8'h09);
		wr(SSR_BASE + 12'd20, 8'h06);
		wr(SCR_BASE + 12'd3, 8'h40);
		wr(SCR_BASE + 12'd20, 8'h40);
		wr(SCR_BASE + 12'd5, 8'h20);
		wr(SCR_BASE + 12'd6, 8'h10);
		rd(SCR_BASE + 12'd6, 8'h10);
		sig[6] = 4'hA;
		send_mf();
		rd(SAR_BASE + 12'd3, {4'h0, sig[3]});
		rd(SAR_BASE + 12'd6, 8'h00);
		slow <= 1'b1;
		send_mf();
		rd(SAR_BASE + 12'd6, 8'h0A);
		rd(SAR_BASE + 12'd20, {4'h0, sig[20]});
		sig[6] = 4'h5;
		sig_chk = 1'b1;
		pat_type = 1'b1;
		de_src = 2'h1;
		user[15] = 8'($urandom);
		wr(PAT_CFG_ADDR, 8'h80);
		wr(DE_CFG_ADDR, 8'h01);
		wr(UCR_BASE + 12'd15, user[15]);
		rd(PAT_CFG_ADDR, 8'h80);
		send_mf();
		rd(SAR_BASE + 12'd6, 8'h0A);
		cmp({7'h0, oh_cnt > 0}, 8'h01);
		for (int i = 0; i < 500 && pq.size() > 0; i++) @(posedge clk);
		cmp(8'(pq.size()), 8'h00);
		cmp(8'(fs_cnt), 8'h30);
		// Stalled drain side: FIFO fills, later octets are dropped
		stall <= 1'b1;
		ignore <= 1'b1;
		send_frame(0);
		rd(STAT_ADDR, 8'h01);
		wr(STAT_ADDR, 8'h01);
		rd(STAT_ADDR, 8'h00);
		stall <= 1'b0;
		repeat (300) @(posedge clk);
		finish_test();
	end
endmodule

//--- rts_fifo.sv
// FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rts_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_q, rd_q;
	logic [PW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Storage needs no reset; out_valid guards every read
	always_ff @(posedge clk) begin
		if (push) mem[wr_q] <= in_data;
	end
endmodule

//--- rts_lfsr.sv
// Byte-wide Fibonacci LFSR pattern generator
`timescale 1ns/100ps
module rts_lfsr #(
	parameter int WIDTH = 15,
	parameter int TAP = 14
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Advance by one octet
	input wire logic step,
	output logic [7:0] pat_byte
);
	logic [WIDTH-1:0] st_q;
	logic [WIDTH-1:0] st_d;
	logic fb;

	// Feedback x^WIDTH + x^TAP + 1, eight bits per step, MSB first
	always_comb begin
		st_d = st_q;
		fb = 1'b0;
		pat_byte = '0;
		for (int i = 0; i < 8; i++) begin
			fb = st_d[WIDTH-1] ^ st_d[TAP-1];
			pat_byte[7-i] = fb;
			st_d = {st_d[WIDTH-2:0], fb};
		end
	end

	// Seed is 1, a non-zero value, so the generator never locks up
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) st_q <= {{(WIDTH-1){1'b0}}, 1'b1};
		else if (step) st_q <= st_d;
	end
endmodule

//--- rts_pkg.sv
// Package: register map, codes and carrier types for receive timeslot conditioning
package rts_pkg;
	localparam int NUM_TS = 32;
	localparam int AW = 12;
	localparam logic [11:0] CCR_BASE = 12'h300;
	localparam logic [11:0] UCR_BASE = 12'h380;
	localparam logic [11:0] SCR_BASE = 12'h3A0;
	localparam logic [11:0] SSR_BASE = 12'h3C0;
	localparam logic [11:0] STAT_ADDR = 12'h3E0;
	localparam logic [11:0] SAR_BASE = 12'h500;
	localparam logic [11:0] PAT_CFG_ADDR = 12'h123;
	localparam logic [11:0] DE_CFG_ADDR = 12'h10C;
	localparam int PAT_TYPE_BIT = 7;
	localparam int SUBST_BIT = 6;
	localparam int OH_BIT = 5;
	localparam int DEB_BIT = 4;
	localparam int OVF_BIT = 0;
	localparam logic [7:0] USER_RESET = 8'hFF;
	localparam logic [3:0] CCR_RESET = 4'h0;
	localparam logic [2:0] SCR_RESET = 3'h0;
	localparam logic [3:0] SSR_RESET = 4'h0;
	// Conditioning select codes
	localparam logic [3:0] COND_PASS = 4'h0;
	localparam logic [3:0] COND_INV_ALL = 4'h1;
	localparam logic [3:0] COND_INV_EVEN = 4'h2;
	localparam logic [3:0] COND_INV_ODD = 4'h3;
	localparam logic [3:0] COND_USER = 4'h4;
	localparam logic [3:0] COND_BUSY = 4'h5;
	localparam logic [3:0] COND_VACANT = 4'h6;
	localparam logic [3:0] COND_BUSY_TS = 4'h7;
	localparam logic [3:0] COND_OOF = 4'h8;
	localparam logic [3:0] COND_ALAW = 4'h9;
	localparam logic [3:0] COND_ULAW = 4'hA;
	localparam logic [3:0] COND_INV_MSB = 4'hB;
	localparam logic [3:0] COND_INV_LOW = 4'hC;
	localparam logic [3:0] COND_PATTERN = 4'hD;
	localparam logic [3:0] COND_PASS2 = 4'hE;
	localparam logic [3:0] COND_DE = 4'hF;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_EVEN = 8'hAA;
	localparam logic [7:0] MASK_ODD = 8'h55;
	localparam logic [7:0] MASK_MSB = 8'h80;
	localparam logic [7:0] MASK_LOW = 8'h7F;
	localparam logic [7:0] CODE_BUSY = 8'h7F;
	localparam logic [7:0] CODE_VACANT = 8'hFF;
	localparam logic [7:0] CODE_OOF = 8'h1A;
	localparam logic [2:0] BUSY_TS_PREFIX = 3'h7;
	localparam logic [7:0] ALAW_DMW [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
	localparam logic [7:0] ULAW_DMW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
	// D/E slot sources
	localparam logic [1:0] DE_SRC_RX = 2'h0;
	localparam logic [1:0] DE_SRC_USER = 2'h1;
	// Line framing
	localparam logic [4:0] TS_SIG = 5'h10;
	localparam logic [3:0] FRAME_MF = 4'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] OH_BITS = 3'h4;
	// Pattern generators
	localparam int PRBS_W = 15;
	localparam int PRBS_TAP = 14;
	localparam int QRTS_W = 20;
	localparam int QRTS_TAP = 17;
	localparam int FIFO_DEPTH = 8;
	typedef struct packed {
		logic [4:0] ts;
		logic [7:0] oct;
	} rts_word_t;
	typedef enum logic {SER_IDLE, SER_SHIFT} rts_ser_t;
endpackage
